/* File: common/clk_mon_pkg.sv */
// shared constants for the clock and boot fault monitor
package clk_mon_pkg;
	localparam int unsigned CLOCK_MHZ      = 200;
	// register offsets (byte addresses)
	localparam logic [7:0] OFS_CONFIG      = 8'h00;
	localparam logic [7:0] OFS_STATUS      = 8'h04;
	localparam logic [7:0] OFS_IRQ_STATUS  = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK    = 8'h0C;
	localparam logic [7:0] OFS_FREQ_RESULT = 8'h10;
	// config fields
	localparam int unsigned CFG_DEAD_CHECK = 0;
	localparam int unsigned CFG_HF_START   = 1;
	localparam int unsigned CFG_HF_PIN_SEL = 2;
	localparam int unsigned CFG_PLL_START  = 3;
	localparam int unsigned CFG_LF_EXT     = 4;
	localparam int unsigned CFG_FREQ_START = 5;
	localparam int unsigned CFG_FREQ_SEL   = 6;
	localparam int unsigned CFG_FREQ_SEL_W = 2;
	localparam int unsigned CFG_FREQ_WIN   = 8;
	localparam int unsigned CFG_FREQ_WIN_W = 8;
	localparam logic [31:0] CONFIG_RESET   = 32'h0000_0100;
	// status fields
	localparam int unsigned ST_HF_GOOD     = 0;
	localparam int unsigned ST_HF_DEAD     = 1;
	localparam int unsigned ST_PLL_GOOD    = 2;
	localparam int unsigned ST_PLL_DEAD    = 3;
	localparam int unsigned ST_LF_DEAD     = 4;
	localparam int unsigned ST_MCLK_FAULT  = 5;
	localparam int unsigned ST_BROWNOUT    = 6;
	localparam int unsigned ST_FREQ_DONE   = 7;
	localparam int unsigned ST_BOOT_FAIL   = 8;
	// interrupt event bits
	localparam int unsigned NUM_EVENTS     = 8;
	localparam int unsigned EV_HF_GOOD     = 0;
	localparam int unsigned EV_HF_DEAD     = 1;
	localparam int unsigned EV_PLL_GOOD    = 2;
	localparam int unsigned EV_PLL_DEAD    = 3;
	localparam int unsigned EV_LF_DEAD     = 4;
	localparam int unsigned EV_MCLK_FAULT  = 5;
	localparam int unsigned EV_BROWNOUT    = 6;
	localparam int unsigned EV_FREQ_DONE   = 7;
	// main clock watch window, in low-frequency clock cycles
	localparam logic [3:0] MCLK_WINDOW_LF  = 4'hC;
	// start-up windows in microseconds
	localparam int unsigned HF_START_US    = 50;
	localparam int unsigned PLL_SETTLE_US  = 40;
	localparam int unsigned START_CNT_W    = 16;
	localparam logic [15:0] HF_START_CYC   = 16'(HF_START_US * CLOCK_MHZ);
	localparam logic [15:0] PLL_SETTLE_CYC = 16'(PLL_SETTLE_US * CLOCK_MHZ);
	// clock edges needed to judge a clock alive
	localparam logic [3:0] ALIVE_EDGES     = 4'h4;
	// low-frequency stuck detection window, in cycles
	localparam logic [15:0] LF_STUCK_CYC   = 16'h2000;
	// boot routine timeout, in cycles
	localparam logic [15:0] BOOT_TIMEOUT   = 16'hC350;
	localparam logic [7:0] BOOT_RESET_LEN  = 8'h10;
endpackage

/* File: rtl/clk_activity.sv */
// rising-edge pulse detector for one asynchronous clock, with three-stage synchroniser
`timescale 1ns/1ps
module clk_activity (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// watched clock
	input  wire logic       clk_in,
	// control
	input  wire logic       clear,
	// result
	output logic            edge_pulse
);
	logic [2:0] sync_q;
	logic       level_q;
	logic       edge_q;
	wire        agree = sync_q[1] ~^ sync_q[2];

	// a change counts only once stages two and three agree, so a one-sample glitch is dropped
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sync_q  <= 3'h0;
			level_q <= 1'b0;
			edge_q  <= 1'b0;
		end else begin
			sync_q  <= {sync_q[1:0], clk_in};
			if (agree) begin
				level_q <= sync_q[2];
			end
			edge_q  <= agree & sync_q[2] & ~level_q & ~clear;
		end
	end

	assign edge_pulse = edge_q;
endmodule

/* File: rtl/clk_boot_monitor.sv */
// clock start-up, clock loss, frequency count and boot fault monitor
//
// Functional notes
// R1: main clock silent 1-12 LF cycles: fault
// R2: main clock fault always issues boot reset
// R3: main monitor runs only when enable set
// R4: monitor idle in deep standby and shutdown
// R5: HF start or pin select clears flags
// R6: report HF start, detect stuck pin input
// R7: PLL enable clears PLL good and dead
// R8: after settle, PLL good flag and interrupt
// R9: PLL not started in time: dead flag
// R10: LF stuck check only for external source
// R11: count source periods over reference window
// R12: boot routine failure asserts boot reset
// R13: config data integrity error: boot reset
// R14: trim data integrity error: boot reset
// R15: boot routine timeout: boot reset
// R16: brownout violation follows supply state
// R17: good and dead never both set
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module clk_boot_monitor (
	// clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [31:0] reg_rdata,
	// watched clocks
	input  wire logic        main_clock,
	input  wire logic        low_freq_clock,
	input  wire logic        high_freq_clock,
	input  wire logic        pll_clock,
	// mode and supply
	input  wire logic        deep_standby_mode,
	input  wire logic        shutdown_mode,
	input  wire logic        brownout_trip,
	// boot configuration routine
	input  wire logic        boot_routine_busy,
	input  wire logic        boot_routine_fail,
	input  wire logic        boot_config_crc_err,
	input  wire logic        trim_crc_err,
	// outputs
	output logic             boot_reset,
	output logic             brownout_violation,
	output logic             irq
);
	localparam int unsigned EW = clk_mon_pkg::NUM_EVENTS;

	logic [31:0]  config_q;
	logic [8:0]   status_q;
	logic [8:0]   status_d;
	logic [EW-1:0] irq_st_q;
	logic [EW-1:0] irq_mask_q;
	logic [31:0]  rdata_q;
	logic [15:0]  freq_result_q;
	logic         irq_q;

	// edge pulses of the four watched clocks
	logic [3:0] clk_vec;
	logic [3:0] edge_p;
	assign clk_vec = {pll_clock, high_freq_clock, low_freq_clock, main_clock};

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_act
			clk_activity u_act (
				.clock      (clock),
				.rst_n      (rst_n),
				.clk_in     (clk_vec[g]),
				.clear      (1'b0),
				.edge_pulse (edge_p[g])
			);
		end
	endgenerate

	wire mclk_edge = edge_p[0];
	wire lf_edge   = edge_p[1];
	wire hf_edge   = edge_p[2];
	wire pll_edge  = edge_p[3];

	// register decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	wire wr_cfg   = reg_write & hit(reg_addr, clk_mon_pkg::OFS_CONFIG);
	wire wr_mask  = reg_write & hit(reg_addr, clk_mon_pkg::OFS_IRQ_MASK);
	wire rd_irqst = reg_read & hit(reg_addr, clk_mon_pkg::OFS_IRQ_STATUS);

	// start strobes: every config write with the control bit set, whatever its old value
	wire hf_start  = wr_cfg & (reg_wdata[clk_mon_pkg::CFG_HF_START] |
		reg_wdata[clk_mon_pkg::CFG_HF_PIN_SEL]);
	wire pll_start = wr_cfg & reg_wdata[clk_mon_pkg::CFG_PLL_START];
	wire freq_start = wr_cfg & reg_wdata[clk_mon_pkg::CFG_FREQ_START];

	wire dead_chk  = config_q[clk_mon_pkg::CFG_DEAD_CHECK];
	wire lf_ext    = config_q[clk_mon_pkg::CFG_LF_EXT];
	wire low_power = deep_standby_mode | shutdown_mode;

	// main clock monitor: LF edges since last main clock edge
	logic [3:0] mclk_lf_cnt_q;
	wire mclk_run   = dead_chk & ~low_power; // [R3] [R4]
	wire mclk_fault = mclk_run & lf_edge &
		(mclk_lf_cnt_q == clk_mon_pkg::MCLK_WINDOW_LF - 4'h1) & ~mclk_edge; // [R1]

	always_ff @(posedge clock) begin
		if (!rst_n || !mclk_run || mclk_edge) begin
			mclk_lf_cnt_q <= 4'h0;
		end else if (lf_edge && mclk_lf_cnt_q != clk_mon_pkg::MCLK_WINDOW_LF) begin
			mclk_lf_cnt_q <= mclk_lf_cnt_q + 4'h1;
		end
	end

	// high-frequency and PLL start-up evaluators
	logic [15:0] hf_cnt_q;
	logic [3:0]  hf_edges_q;
	logic        hf_busy_q;
	logic [15:0] pll_cnt_q;
	logic [3:0]  pll_edges_q;
	logic        pll_busy_q;

	wire hf_done   = hf_busy_q & (hf_cnt_q == clk_mon_pkg::HF_START_CYC);
	wire hf_ok     = hf_edges_q == clk_mon_pkg::ALIVE_EDGES;
	wire pll_done  = pll_busy_q & (pll_cnt_q == clk_mon_pkg::PLL_SETTLE_CYC);
	wire pll_ok    = pll_edges_q == clk_mon_pkg::ALIVE_EDGES;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			hf_busy_q   <= 1'b0;
			hf_cnt_q    <= 16'h0000;
			hf_edges_q  <= 4'h0;
		end else if (hf_start) begin
			hf_busy_q   <= 1'b1;
			hf_cnt_q    <= 16'h0000;
			hf_edges_q  <= 4'h0;
		end else if (hf_busy_q) begin
			hf_busy_q   <= ~hf_done;
			hf_cnt_q    <= hf_cnt_q + 16'h0001;
			if (hf_edge && !hf_ok) begin
				hf_edges_q <= hf_edges_q + 4'h1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pll_busy_q  <= 1'b0;
			pll_cnt_q   <= 16'h0000;
			pll_edges_q <= 4'h0;
		end else if (pll_start) begin
			pll_busy_q  <= 1'b1;
			pll_cnt_q   <= 16'h0000;
			pll_edges_q <= 4'h0;
		end else if (pll_busy_q) begin
			pll_busy_q  <= ~pll_done;
			pll_cnt_q   <= pll_cnt_q + 16'h0001;
			if (pll_edge && !pll_ok) begin
				pll_edges_q <= pll_edges_q + 4'h1;
			end
		end
	end

	// low-frequency stuck check; only external sources are watched
	logic [15:0] lf_idle_q;
	wire lf_stuck = lf_ext & (lf_idle_q == clk_mon_pkg::LF_STUCK_CYC); // [R10]

	always_ff @(posedge clock) begin
		if (!rst_n || !lf_ext || lf_edge) begin
			lf_idle_q <= 16'h0000;
		end else if (!lf_stuck) begin
			lf_idle_q <= lf_idle_q + 16'h0001;
		end
	end

	// frequency counter: main, LF, HF or PLL periods over a window of LF periods
	logic [15:0] freq_cnt_q;
	logic [7:0]  freq_win_q;
	logic        freq_busy_q;
	wire [1:0] freq_sel = config_q[clk_mon_pkg::CFG_FREQ_SEL +: clk_mon_pkg::CFG_FREQ_SEL_W];
	wire [7:0] freq_len = config_q[clk_mon_pkg::CFG_FREQ_WIN +: clk_mon_pkg::CFG_FREQ_WIN_W];
	wire freq_src  = edge_p[freq_sel];
	wire freq_done = freq_busy_q & lf_edge & (freq_win_q == freq_len);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			freq_busy_q   <= 1'b0;
			freq_cnt_q    <= 16'h0000;
			freq_win_q    <= 8'h00;
			freq_result_q <= 16'h0000;
		end else if (freq_start) begin
			freq_busy_q   <= 1'b1;
			freq_cnt_q    <= 16'h0000;
			freq_win_q    <= 8'h00;
		end else if (freq_busy_q) begin
			// window opens at the first reference edge
			if (lf_edge) begin
				freq_win_q <= freq_win_q + 8'h01;
			end
			if (freq_src && freq_win_q != 8'h00) begin
				freq_cnt_q <= freq_cnt_q + 16'h0001; // [R11]
			end
			if (freq_done) begin
				freq_busy_q   <= 1'b0;
				freq_result_q <= freq_cnt_q; // [R11]
			end
		end
	end

	// boot process monitor
	logic [15:0] boot_cnt_q;
	logic [7:0]  boot_rst_cnt_q;
	wire boot_timeout = boot_routine_busy & (boot_cnt_q == clk_mon_pkg::BOOT_TIMEOUT); // [R15]
	wire boot_fail    = boot_routine_busy & (boot_routine_fail | boot_config_crc_err |
		trim_crc_err | boot_timeout); // [R12] [R13] [R14]
	wire boot_trig    = boot_fail | mclk_fault; // [R2]

	always_ff @(posedge clock) begin
		if (!rst_n || !boot_routine_busy) begin
			boot_cnt_q <= 16'h0000;
		end else if (!boot_timeout) begin
			boot_cnt_q <= boot_cnt_q + 16'h0001;
		end
	end

	// boot reset is held for a fixed count so the boot sequencer sees it
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			boot_rst_cnt_q <= 8'h00;
		end else if (boot_trig) begin
			boot_rst_cnt_q <= clk_mon_pkg::BOOT_RESET_LEN;
		end else if (boot_rst_cnt_q != 8'h00) begin
			boot_rst_cnt_q <= boot_rst_cnt_q - 8'h01;
		end
	end

	// status flags; a start clears, an evaluation sets exactly one of good or dead
	always_comb begin
		status_d = status_q;
		if (hf_start) begin
			status_d[clk_mon_pkg::ST_HF_GOOD] = 1'b0; // [R5]
			status_d[clk_mon_pkg::ST_HF_DEAD] = 1'b0; // [R5]
		end else if (hf_done) begin
			status_d[clk_mon_pkg::ST_HF_GOOD] = hf_ok;  // [R6] [R17]
			status_d[clk_mon_pkg::ST_HF_DEAD] = ~hf_ok; // [R6] [R17]
		end
		if (pll_start) begin
			status_d[clk_mon_pkg::ST_PLL_GOOD] = 1'b0; // [R7]
			status_d[clk_mon_pkg::ST_PLL_DEAD] = 1'b0; // [R7]
		end else if (pll_done) begin
			status_d[clk_mon_pkg::ST_PLL_GOOD] = pll_ok;  // [R8] [R17]
			status_d[clk_mon_pkg::ST_PLL_DEAD] = ~pll_ok; // [R9] [R17]
		end
		status_d[clk_mon_pkg::ST_LF_DEAD] = lf_stuck;
		if (mclk_fault) begin
			status_d[clk_mon_pkg::ST_MCLK_FAULT] = 1'b1;
		end else if (!dead_chk) begin
			status_d[clk_mon_pkg::ST_MCLK_FAULT] = 1'b0;
		end
		status_d[clk_mon_pkg::ST_BROWNOUT] = brownout_trip; // [R16]
		if (freq_start) begin
			status_d[clk_mon_pkg::ST_FREQ_DONE] = 1'b0;
		end else if (freq_done) begin
			status_d[clk_mon_pkg::ST_FREQ_DONE] = 1'b1;
		end
		if (boot_fail) begin
			status_d[clk_mon_pkg::ST_BOOT_FAIL] = 1'b1;
		end
	end

	// interrupt events, sticky; an event in the read cycle survives the clear
	logic [EW-1:0] events;
	assign events[clk_mon_pkg::EV_HF_GOOD]    = hf_done & hf_ok;
	assign events[clk_mon_pkg::EV_HF_DEAD]    = hf_done & ~hf_ok;
	assign events[clk_mon_pkg::EV_PLL_GOOD]   = pll_done & pll_ok; // [R8]
	assign events[clk_mon_pkg::EV_PLL_DEAD]   = pll_done & ~pll_ok;
	assign events[clk_mon_pkg::EV_LF_DEAD]    = lf_stuck & ~status_q[clk_mon_pkg::ST_LF_DEAD];
	assign events[clk_mon_pkg::EV_MCLK_FAULT] = mclk_fault;
	assign events[clk_mon_pkg::EV_BROWNOUT]   =
		brownout_trip & ~status_q[clk_mon_pkg::ST_BROWNOUT];
	assign events[clk_mon_pkg::EV_FREQ_DONE]  = freq_done;

	wire [EW-1:0] irq_st_d = (rd_irqst ? {EW{1'b0}} : irq_st_q) | events;

	// read mux
	logic [31:0] rdata_d;
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (reg_read) begin
			unique case (reg_addr)
				clk_mon_pkg::OFS_CONFIG:     rdata_d = config_q;
				clk_mon_pkg::OFS_STATUS:     rdata_d = {23'h0, status_q};
				clk_mon_pkg::OFS_IRQ_STATUS: rdata_d = {24'h000000, irq_st_q};
				clk_mon_pkg::OFS_IRQ_MASK:   rdata_d = {24'h000000, irq_mask_q};
				clk_mon_pkg::OFS_FREQ_RESULT: rdata_d = {16'h0000, freq_result_q};
				default:                     rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// start bits are self-clearing; the rest hold what software wrote
	wire [31:0] start_bits = (32'h1 << clk_mon_pkg::CFG_HF_START) |
		(32'h1 << clk_mon_pkg::CFG_PLL_START) | (32'h1 << clk_mon_pkg::CFG_FREQ_START);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			config_q           <= clk_mon_pkg::CONFIG_RESET;
			status_q           <= 9'h000;
			irq_st_q           <= {EW{1'b0}};
			irq_mask_q         <= {EW{1'b0}};
			rdata_q            <= 32'h0000_0000;
			irq_q              <= 1'b0;
			boot_reset         <= 1'b0;
			brownout_violation <= 1'b0;
		end else begin
			if (wr_cfg) begin
				config_q <= reg_wdata & ~start_bits; // [R3]
			end
			if (wr_mask) begin
				irq_mask_q <= reg_wdata[EW-1:0];
			end
			status_q           <= status_d;
			irq_st_q           <= irq_st_d;
			rdata_q            <= rdata_d;
			irq_q              <= |(irq_st_d & irq_mask_q);
			boot_reset         <= boot_trig | (boot_rst_cnt_q > 8'h01); // [R2] [R12]
			brownout_violation <= brownout_trip; // [R16]
		end
	end

	assign reg_rdata = rdata_q;
	assign irq       = irq_q;
endmodule

/* File: testbench/clk_boot_monitor_sva.sv */
// port-level assertions for the clock and boot fault monitor
`timescale 1ns/1ps
module clk_boot_monitor_sva (
	// clock and reset
	input wire logic        clock,
	input wire logic        rst_n,
	// register port
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [31:0] reg_rdata,
	// watched clocks
	input wire logic        main_clock,
	input wire logic        low_freq_clock,
	input wire logic        high_freq_clock,
	input wire logic        pll_clock,
	// mode and supply
	input wire logic        deep_standby_mode,
	input wire logic        shutdown_mode,
	input wire logic        brownout_trip,
	// boot configuration routine
	input wire logic        boot_routine_busy,
	input wire logic        boot_routine_fail,
	input wire logic        boot_config_crc_err,
	input wire logic        trim_crc_err,
	// outputs
	input wire logic        boot_reset,
	input wire logic        brownout_violation,
	input wire logic        irq
);
	logic [7:0] mask_q;
	logic       st_rd_q;

	// shadow of the mask so irq can be judged without peeking inside
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mask_q  <= 8'h00;
			st_rd_q <= 1'b0;
		end else begin
			if (reg_write && reg_addr == clk_mon_pkg::OFS_IRQ_MASK)
				mask_q <= reg_wdata[7:0];
			st_rd_q <= reg_read && reg_addr == clk_mon_pkg::OFS_STATUS;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	AST_RESET_QUIET:
		assert property (!$past(rst_n) |-> !boot_reset && !irq && !brownout_violation)
		else $error("output active right after reset");
	AST_BROWNOUT_COPY:
		assert property ($past(rst_n) |-> brownout_violation == $past(brownout_trip))
		else $error("brownout violation does not follow the supply trip");
	AST_BOOT_FAIL_RESET:
		assert property (boot_routine_busy && boot_routine_fail |=> boot_reset)
		else $error("boot failure without boot reset");
	AST_CFG_CRC_RESET:
		assert property (boot_routine_busy && boot_config_crc_err |-> ##1 boot_reset)
		else $error("config integrity error without boot reset");
	AST_TRIM_CRC_RESET:
		assert property ($rose(trim_crc_err) && boot_routine_busy |-> ##1 boot_reset)
		else $error("trim integrity error without boot reset");
	AST_BOOT_RESET_LEN:
		assert property ($rose(boot_reset) |-> boot_reset [*8] ##1 boot_reset [*8])
		else $error("boot reset pulse shorter than 16 cycles");
	AST_RDATA_IDLE:
		assert property (!$past(reg_read) |-> reg_rdata == 32'h0000_0000)
		else $error("read data outside its cycle");
	AST_GOOD_DEAD_EXCL:
		assert property (st_rd_q |-> !(reg_rdata[clk_mon_pkg::ST_HF_GOOD]
			&& reg_rdata[clk_mon_pkg::ST_HF_DEAD]) && !(reg_rdata[clk_mon_pkg::ST_PLL_GOOD]
			&& reg_rdata[clk_mon_pkg::ST_PLL_DEAD]))
		else $error("good and dead flags set together");
	AST_IRQ_MASKED:
		assert property (mask_q == 8'h00 && $past(mask_q) == 8'h00 |-> !irq)
		else $error("irq high with every source masked");

	COV_BOOT_RESET: cover property ($rose(boot_reset));
	COV_IRQ:        cover property ($rose(irq));
	COV_PLL_GOOD:   cover property (st_rd_q && reg_rdata[clk_mon_pkg::ST_PLL_GOOD]);
endmodule

bind clk_boot_monitor clk_boot_monitor_sva i_clk_boot_monitor_sva (
	.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
	.main_clock, .low_freq_clock, .high_freq_clock, .pll_clock,
	.deep_standby_mode, .shutdown_mode, .brownout_trip,
	.boot_routine_busy, .boot_routine_fail, .boot_config_crc_err, .trim_crc_err,
	.boot_reset, .brownout_violation, .irq
);

/* File: testbench/clk_boot_monitor_tb.sv */
// self-checking bench for the clock and boot fault monitor
`timescale 1ns/1ps
module clk_boot_monitor_tb;
	typedef struct {
		logic [31:0] e;
		logic [31:0] m;
		int          tol;
	} note_t;
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic [31:0] reg_rdata;
	logic        main_clock = 1'b0;
	logic        low_freq_clock = 1'b0;
	logic        high_freq_clock = 1'b0;
	logic        pll_clock = 1'b0;
	logic        deep_standby_mode = 1'b0;
	logic        shutdown_mode = 1'b0;
	logic        brownout_trip = 1'b0;
	logic        busy = 1'b0;
	logic [2:0]  berr = 3'h0;
	logic        boot_reset;
	logic        brownout_violation;
	logic        irq;
	logic        main_run = 1'b1;
	logic        lf_run = 1'b1;
	logic        hf_run = 1'b1;
	logic        pll_run = 1'b1;
	logic        rd_seen = 1'b0;
	int          brst_cycles = 0;
	int          brst_mark = 0;
	note_t       notes[$];
	note_t       n;
	logic [31:0] d;
	int          n_errors = 0;
	int          n_compared = 0;
	int          cycles = 0;
	int          k;
	int          j;
	int          w;
	int          per[4] = '{10, 1, 8, 5};

	// watched clocks hold their level while stopped; periods give 10/1/8/5 edges per slow period
	always #2.5 clock = ~clock;
	always #10 main_clock = main_clock ^ main_run;
	always #100 low_freq_clock = low_freq_clock ^ lf_run;
	always #12.5 high_freq_clock = high_freq_clock ^ hf_run;
	always #20 pll_clock = pll_clock ^ pll_run;

	clk_boot_monitor i_clk_boot_monitor (
		.clock, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
		.main_clock, .low_freq_clock, .high_freq_clock, .pll_clock,
		.deep_standby_mode, .shutdown_mode, .brownout_trip,
		.boot_routine_busy(busy), .boot_routine_fail(berr[0]),
		.boot_config_crc_err(berr[1]), .trim_crc_err(berr[2]),
		.boot_reset, .brownout_violation, .irq
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		if (n_errors == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input int tol);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		notes.push_back(note_t'{e, m, tol});
		@(posedge clock);
		reg_read <= 1'b0;
	endtask

	// ends on a falling edge so outputs launched by the last rising edge have settled
	task automatic cyc_wait(input int c);
		repeat (c) @(posedge clock);
		@(negedge clock);
	endtask

	// read data stand only in the cycle after the strobe
	always @(posedge clock) begin
		cycles++;
		if (boot_reset === 1'b1)
			brst_cycles++;
		if (rd_seen) begin
			n = notes.pop_front();
			d = reg_rdata & n.m;
			if (n.tol > 0 && d + n.tol >= n.e && d <= n.e + n.tol)
				d = n.e;
			check(d, n.e);
		end
		rd_seen <= reg_read;
		if (cycles == 98000) begin
			n_errors++;
			$display("CHECK FAILED at %0t: run too long", $time);
			report_and_stop();
		end
	end

	initial begin
		void'($urandom(32'h9479ab10));
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		rd(clk_mon_pkg::OFS_CONFIG, clk_mon_pkg::CONFIG_RESET, 32'hFFFF_FFFF, 0);
		rd(clk_mon_pkg::OFS_STATUS, 32'h0, 32'h0000_01FF, 0);
		wr(8'h14, 32'hFFFF_FFFF);
		rd(8'h14, 32'h0, 32'hFFFF_FFFF, 0);
		wr(clk_mon_pkg::OFS_IRQ_MASK, 32'h0);
		rd(clk_mon_pkg::OFS_IRQ_MASK, 32'h0, 32'h0000_00FF, 0);
		// supply drop while masked, then unmask and clear by reading
		brownout_trip <= 1'b1;
		cyc_wait(3);
		check(32'(brownout_violation), 32'h1);
		check(32'(irq), 32'h0);
		wr(clk_mon_pkg::OFS_IRQ_MASK, 32'h40);
		cyc_wait(3);
		check(32'(irq), 32'h1);
		rd(clk_mon_pkg::OFS_STATUS, 32'h40, 32'h40, 0);
		rd(clk_mon_pkg::OFS_IRQ_STATUS, 32'h40, 32'h40, 0);
		cyc_wait(3);
		check(32'(irq), 32'h0);
		@(posedge clock);
		brownout_trip <= 1'b0;
		cyc_wait(3);
		check(32'(brownout_violation), 32'h0);
		// start-up with both sources dead, then restart them alive
		hf_run = 1'b0;
		pll_run = 1'b0;
		rd(clk_mon_pkg::OFS_IRQ_STATUS, 32'h0, 32'h0, 0);
		wr(clk_mon_pkg::OFS_CONFIG, 32'h0000_010A);
		rd(clk_mon_pkg::OFS_STATUS, 32'h0, 32'hF, 0);
		cyc_wait(10100);
		rd(clk_mon_pkg::OFS_STATUS, 32'hA, 32'hF, 0);
		rd(clk_mon_pkg::OFS_IRQ_STATUS, 32'hA, 32'hF, 0);
		hf_run = 1'b1;
		pll_run = 1'b1;
		wr(clk_mon_pkg::OFS_CONFIG, 32'h0000_010C);
		rd(clk_mon_pkg::OFS_STATUS, 32'h0, 32'hF, 0);
		cyc_wait(10100);
		rd(clk_mon_pkg::OFS_STATUS, 32'h5, 32'hF, 0);
		rd(clk_mon_pkg::OFS_IRQ_STATUS, 32'h5, 32'hF, 0);
		// stuck slow clock is only reported for an external source
		for (k = 0; k < 2; k++) begin
			wr(clk_mon_pkg::OFS_CONFIG, 32'h0000_0104 | (32'(k) << 4));
			lf_run = 1'b0;
			cyc_wait(8400);
			rd(clk_mon_pkg::OFS_STATUS, 32'(k) << 4, 32'h10, 0);
			lf_run = 1'b1;
		end
		// main clock watch: quiet when healthy, disabled or in low power
		brst_mark = brst_cycles;
		wr(clk_mon_pkg::OFS_CONFIG, 32'h0000_0115);
		cyc_wait(600);
		check(32'(brst_cycles - brst_mark), 32'h0);
		main_run = 1'b0;
		wr(clk_mon_pkg::OFS_CONFIG, 32'h0000_0114);
		cyc_wait(600);
		check(32'(brst_cycles - brst_mark), 32'h0);
		for (k = 0; k < 2; k++) begin
			@(posedge clock);
			deep_standby_mode <= (k == 0);
			shutdown_mode <= (k == 1);
			wr(clk_mon_pkg::OFS_CONFIG, 32'h0000_0115);
			cyc_wait(600);
			check(32'(brst_cycles - brst_mark), 32'h0);
			wr(clk_mon_pkg::OFS_CONFIG, 32'h0000_0114);
		end
		deep_standby_mode <= 1'b0;
		shutdown_mode <= 1'b0;
		wr(clk_mon_pkg::OFS_CONFIG, 32'h0000_0115);
		for (j = 0; j < 600 && boot_reset !== 1'b1; j++) @(negedge clock);
		check(32'(boot_reset), 32'h1);
		rd(clk_mon_pkg::OFS_STATUS, 32'h20, 32'h20, 0);
		main_run = 1'b1;
		wr(clk_mon_pkg::OFS_CONFIG, 32'h0000_0114);
		cyc_wait(4);
		rd(clk_mon_pkg::OFS_STATUS, 32'h0, 32'h20, 0);
		// each of the three boot error inputs in turn
		for (k = 0; k < 3; k++) begin
			for (j = 0; j < 100 && boot_reset !== 1'b0; j++) @(negedge clock);
			@(posedge clock);
			busy <= 1'b1;
			@(posedge clock);
			berr <= 3'h1 << k;
			@(posedge clock);
			berr <= 3'h0;
			for (j = 0; j < 4 && boot_reset !== 1'b1; j++) @(negedge clock);
			check(32'(boot_reset), 32'h1);
			@(posedge clock);
			busy <= 1'b0;
		end
		rd(clk_mon_pkg::OFS_STATUS, 32'h100, 32'h100, 0);
		// frequency count of every source over a random window
		wr(clk_mon_pkg::OFS_IRQ_MASK, 32'h80);
		for (k = 0; k < 4; k++) begin
			w = 2 + $urandom % 8;
			rd(clk_mon_pkg::OFS_IRQ_STATUS, 32'h0, 32'h0, 0);
			wr(clk_mon_pkg::OFS_CONFIG, 32'h34 | (32'(w) << 8) | (32'(k) << 6));
			for (j = 0; j < 600 && irq !== 1'b1; j++) @(negedge clock);
			check(32'(irq), 32'h1);
			rd(clk_mon_pkg::OFS_FREQ_RESULT, 32'(w * per[k]), 32'h0000_FFFF, 2);
		end
		// a boot routine that never finishes is cut off by the timeout, not earlier
		@(posedge clock);
		busy <= 1'b1;
		for (j = 0; j < 50100 && boot_reset !== 1'b1; j++) @(negedge clock);
		check(32'(boot_reset), 32'h1);
		check(32'(j > clk_mon_pkg::BOOT_TIMEOUT), 32'h1);
		@(posedge clock);
		busy <= 1'b0;
		cyc_wait(4);
		report_and_stop();
	end
endmodule
